// file: rtl/cache_capacity_partition_config.sv
// Purpose: Per-space cache capacity limit settings per partition
// Assumes: Caller presents the selector fields of the addressed space's frame
// Notes:   One access in flight; answer two edges after the request
//          Refused selections answer with an error flag and zero data
//          Lookups share the sequencer and yield to software accesses
//          Absent registers read zero and drop writes without an error

`timescale 1ns/1ps

module cache_capacity_partition_config #(
  parameter bit INSTANCE_SELECT_PRESENT       = 1'b1,
  parameter bit NARROWING_PRESENT             = 1'b0,
  parameter bit FOUR_SPACE_PRESENT            = 1'b1,
  parameter bit CAPACITY_PARTITIONING_PRESENT = 1'b1,
  parameter bit LATER_REVISION                = 1'b1,
  parameter bit MIN_CAPACITY_PRESENT          = 1'b1,
  parameter bit SOFT_LIMIT_PRESENT            = 1'b1
) (
  input  wire logic                                         sys_clk,
  input  wire logic                                         rstn,
  input  wire logic                                         acc_req,
  input  wire logic [capacity_cfg_pkg::SPACE_BITS-1:0]      acc_space,
  input  wire logic [capacity_cfg_pkg::ADDR_WIDTH-1:0]      acc_addr,
  input  wire logic                                         acc_write,
  input  wire logic [31:0]                                  acc_wdata,
  input  wire logic [capacity_cfg_pkg::SELECT_WIDTH-1:0]    sel_partition,
  input  wire logic [capacity_cfg_pkg::INSTANCE_FIELD-1:0]  sel_instance,
  input  wire logic                                         sel_internal,
  input  wire logic                                         lkp_req,
  input  wire logic [capacity_cfg_pkg::SPACE_BITS-1:0]      lkp_space,
  input  wire logic [capacity_cfg_pkg::INSTANCE_BITS-1:0]   lkp_instance,
  input  wire logic [capacity_cfg_pkg::PARTITION_BITS-1:0]  lkp_partition,
  output logic                                              acc_busy,
  output logic                                              acc_ack,
  output logic                                              acc_error,
  output logic      [31:0]                                  acc_rdata,
  output logic                                              lkp_valid,
  output logic      [capacity_cfg_pkg::FIELD_WIDTH-1:0]     lkp_max_fraction,
  output logic                                              lkp_relax,
  output logic      [capacity_cfg_pkg::FIELD_WIDTH-1:0]     lkp_min_fraction
);

  // ==========================================================================
  // Local widths and feature gates
  // ==========================================================================
  localparam int unsigned FW = capacity_cfg_pkg::FIELD_WIDTH;
  localparam int unsigned IB = capacity_cfg_pkg::INDEX_BITS;
  localparam int unsigned PB = capacity_cfg_pkg::PARTITION_BITS;
  localparam int unsigned NB = capacity_cfg_pkg::INSTANCE_BITS;

  // Register presence follows the feature set; an absent register becomes a
  // reserved word, so software probing an unbuilt feature sees no error
  // Relax bit needs the later revision as well as soft limit support
  localparam bit MAX_PRESENT  = CAPACITY_PARTITIONING_PRESENT;
  localparam bit MIN_PRESENT  = CAPACITY_PARTITIONING_PRESENT &&
                                LATER_REVISION && MIN_CAPACITY_PRESENT;
  localparam bit RELAX_PRESENT = LATER_REVISION && SOFT_LIMIT_PRESENT;

  // ==========================================================================
  // State of the block
  // ==========================================================================
  typedef struct packed {
    capacity_cfg_pkg::state_type fsm;
    logic                        busy;
    logic                        is_lookup;
    logic                        tgt_max;
    logic                        tgt_min;
    logic                        fail;
    logic                        ack;
    logic                        err;
    logic [31:0]                 rdata;
    logic                        lvalid;
    logic [FW-1:0]               lmax;
    logic                        lrelax;
    logic [FW-1:0]               lmin;
  } regs_type;

  // Current record and its next value
  regs_type regs_q;
  regs_type regs_d;

  // ==========================================================================
  // Decode of the software access
  // ==========================================================================
  logic          frame_open;
  logic          internal_ok;
  logic          partition_ok;
  logic          instance_ok;
  logic          select_ok;
  logic          hit_max_addr;
  logic          hit_min_addr;
  logic [NB-1:0] inst_eff;
  logic [IB-1:0] acc_index;
  logic [IB-1:0] lkp_index;
  logic [FW-1:0] wr_fraction;
  logic          max_target;
  logic          min_target;
  logic          lkp_take;

  // Secure and non-secure frames always open; root and realm need four spaces
  assign frame_open = (acc_space == capacity_cfg_pkg::SPACE_SECURE) ||
                      (acc_space == capacity_cfg_pkg::SPACE_NONSECURE) ||
                      FOUR_SPACE_PRESENT;

  // Internal bit must match whether narrowing is built in
  assign internal_ok = NARROWING_PRESENT ? sel_internal
                                         : !sel_internal;

  // Out-of-range partitions and instances address nothing
  assign partition_ok = sel_partition < capacity_cfg_pkg::PARTITION_COUNT;
  assign instance_ok  = !INSTANCE_SELECT_PRESENT ||
                        (sel_instance < capacity_cfg_pkg::INSTANCE_COUNT);

  // Instance field ignored when instance selection is absent
  assign inst_eff = INSTANCE_SELECT_PRESENT ? sel_instance[NB-1:0]
                                            : '0;

  // Space forms the top of the index, so spaces never share a setting
  assign acc_index = {acc_space, inst_eff, sel_partition[PB-1:0]};
  assign lkp_index = {lkp_space, lkp_instance, lkp_partition};

  // Any failed check refuses the access as a whole
  assign select_ok = frame_open && internal_ok && partition_ok && instance_ok;

  // Same word offsets in every frame
  assign hit_max_addr = acc_addr == capacity_cfg_pkg::MAX_OFFSET;
  assign hit_min_addr = acc_addr == capacity_cfg_pkg::MIN_OFFSET;

  // Register present, offset hit, selection legal; refusals never touch a table
  assign max_target = hit_max_addr && MAX_PRESENT && select_ok;
  assign min_target = hit_min_addr && MIN_PRESENT && select_ok;

  // A lookup only starts when no software access competes for the sequencer
  assign lkp_take = lkp_req && !acc_req;

  // ==========================================================================
  // Settings tables and write data shaping
  // ==========================================================================
  // Table ports; writes land at the edge that takes the access
  logic          max_we;
  logic          min_we;
  logic [IB-1:0] rd_index;
  logic [FW:0]   max_word;
  logic [FW-1:0] min_word;

  // Both fractions share one implemented width
  fraction_mask #(
    .FIELD (FW),
    .IMPL  (capacity_cfg_pkg::FRACTION_WIDTH)
  ) u_wr_mask (
    .raw_fraction  (acc_wdata[FW-1:0]),
    .kept_fraction (wr_fraction)
  );

  // Relax bit kept beside the max fraction
  capacity_table #(
    .WIDTH (FW + 1),
    .DEPTH (capacity_cfg_pkg::TABLE_DEPTH),
    .IBITS (IB)
  ) u_max_table (
    .sys_clk   (sys_clk),
    .rstn      (rstn),
    .wr_en     (max_we),
    .wr_index  (acc_index),
    .wr_data   ({acc_wdata[capacity_cfg_pkg::RELAX_BIT] & RELAX_PRESENT, wr_fraction}),
    .rd_index  (rd_index),
    .rd_data_q (max_word)
  );

  capacity_table #(
    .WIDTH (FW),
    .DEPTH (capacity_cfg_pkg::TABLE_DEPTH),
    .IBITS (IB)
  ) u_min_table (
    .sys_clk   (sys_clk),
    .rstn      (rstn),
    .wr_en     (min_we),
    .wr_index  (acc_index),
    .wr_data   (wr_fraction),
    .rd_index  (rd_index),
    .rd_data_q (min_word)
  );

  // ==========================================================================
  // Sequencer
  // ==========================================================================
  // Software access wins over a lookup offered in the same cycle
  // Timing, counted from the edge that takes a request:
  //   edge 0  request taken, table written, old word read out
  //   edge 1  word moved into the answer registers
  //   after   answer stands for one cycle, sequencer idle again
  // A write thus answers with the word held before it; requests while busy are dropped
  always_comb begin
    regs_d        = regs_q;
    regs_d.ack    = 1'b0;
    regs_d.lvalid = 1'b0;
    max_we        = 1'b0;
    min_we        = 1'b0;
    rd_index      = acc_index;
    case (regs_q.fsm)
      capacity_cfg_pkg::ST_IDLE: begin
        if (acc_req) begin
          regs_d.fsm       = capacity_cfg_pkg::ST_FETCH;
          regs_d.busy      = 1'b1;
          regs_d.is_lookup = 1'b0;
          regs_d.tgt_max   = max_target;
          regs_d.tgt_min   = min_target;
          regs_d.fail      = ((hit_max_addr && MAX_PRESENT) || (hit_min_addr && MIN_PRESENT)) && !select_ok;
          // Write lands at this edge; the read beside it still sees the old word
          max_we           = acc_write && max_target;
          min_we           = acc_write && min_target;
        end else if (lkp_take) begin
          regs_d.fsm       = capacity_cfg_pkg::ST_FETCH;
          regs_d.busy      = 1'b1;
          regs_d.is_lookup = 1'b1;
          rd_index         = lkp_index;
        end
      end
      capacity_cfg_pkg::ST_FETCH: begin
        regs_d.fsm  = capacity_cfg_pkg::ST_IDLE;
        regs_d.busy = 1'b0;
        if (regs_q.is_lookup) begin
          // Lookup answer; min fraction forced to zero when the register is absent
          regs_d.lvalid = 1'b1;
          regs_d.lmax   = max_word[FW-1:0];
          regs_d.lrelax = max_word[FW];
          regs_d.lmin   = MIN_PRESENT ? min_word : '0;
        end else begin
          regs_d.ack   = 1'b1;
          regs_d.err   = regs_q.fail;
          regs_d.rdata = 32'h0000_0000;
          // Read data; unmapped, absent or refused words read zero
          if (regs_q.tgt_max) begin
            regs_d.rdata[FW-1:0]                     = max_word[FW-1:0];
            regs_d.rdata[capacity_cfg_pkg::RELAX_BIT] = max_word[FW];
          end else if (regs_q.tgt_min) begin
            regs_d.rdata[FW-1:0] = min_word;
          end
        end
      end
      default: begin
        // Unreachable with a one-bit state; kept so any odd value returns to idle
        regs_d.fsm  = capacity_cfg_pkg::ST_IDLE;
        regs_d.busy = 1'b0;
      end
    endcase
  end

  // State register; reset leaves every answer at zero so nothing stale is offered
  // Only constants in the reset branch; the record copy is taken whole otherwise
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      regs_q.fsm       <= capacity_cfg_pkg::ST_IDLE;
      regs_q.busy      <= 1'b0;
      regs_q.is_lookup <= 1'b0;
      regs_q.tgt_max   <= 1'b0;
      regs_q.tgt_min   <= 1'b0;
      regs_q.fail      <= 1'b0;
      regs_q.ack       <= 1'b0;
      regs_q.err       <= 1'b0;
      regs_q.rdata     <= 32'h0000_0000;
      regs_q.lvalid    <= 1'b0;
      regs_q.lmax      <= capacity_cfg_pkg::FRACTION_RESET;
      regs_q.lrelax    <= capacity_cfg_pkg::RELAX_RESET;
      regs_q.lmin      <= capacity_cfg_pkg::FRACTION_RESET;
    end else begin
      regs_q <= regs_d;
    end
  end

  // ==========================================================================
  // Outputs, all straight from flops
  // ==========================================================================
  // Read data, error and lookup fields hold until the next answer, so a slow reader still finds them
  assign acc_busy         = regs_q.busy;
  assign acc_ack          = regs_q.ack;
  assign acc_error        = regs_q.err;
  assign acc_rdata        = regs_q.rdata;
  assign lkp_valid        = regs_q.lvalid;
  assign lkp_max_fraction = regs_q.lmax;
  assign lkp_relax        = regs_q.lrelax;
  assign lkp_min_fraction = regs_q.lmin;

endmodule

// file: rtl/capacity_cfg_pkg.sv
// Purpose: Shared constants and types of the cache capacity configuration bank
// Assumes: One frame per security space, byte addressed, 32-bit words
// Notes:   Table geometry is fixed here; feature presence is set on the top module

package capacity_cfg_pkg;

  // ==========================================================================
  // Register map inside each space's configuration page
  // ==========================================================================
  localparam int unsigned          ADDR_WIDTH   = 16;
  localparam logic [ADDR_WIDTH-1:0] MAX_OFFSET  = 16'h0108;
  localparam logic [ADDR_WIDTH-1:0] MIN_OFFSET  = 16'h0110;

  // ==========================================================================
  // Field layout
  // ==========================================================================
  localparam int unsigned FIELD_WIDTH    = 16;  // Fraction field, bits 15..0
  localparam int unsigned FRACTION_WIDTH = 8;   // Implemented top bits of it
  localparam int unsigned RELAX_BIT      = 31;  // Over-limit relax control
  localparam logic [FIELD_WIDTH-1:0] FRACTION_RESET = 16'h0000;
  localparam logic                   RELAX_RESET    = 1'b0;

  // ==========================================================================
  // Table geometry: space, instance, partition
  // ==========================================================================
  localparam int unsigned SPACE_BITS     = 2;
  localparam int unsigned INSTANCE_BITS  = 1;
  localparam int unsigned PARTITION_BITS = 3;
  localparam int unsigned SELECT_WIDTH   = 16;  // Partition select field width
  localparam int unsigned INSTANCE_FIELD = 4;   // Resource instance field width
  localparam logic [SELECT_WIDTH-1:0]   PARTITION_COUNT = 16'h0008;
  localparam logic [INSTANCE_FIELD-1:0] INSTANCE_COUNT  = 4'h2;
  localparam int unsigned INDEX_BITS  = SPACE_BITS + INSTANCE_BITS + PARTITION_BITS;
  localparam int unsigned TABLE_DEPTH = 1 << INDEX_BITS;

  // Security spaces, one frame each
  typedef enum logic [SPACE_BITS-1:0] {
    SPACE_SECURE    = 2'h0,
    SPACE_NONSECURE = 2'h1,
    SPACE_ROOT      = 2'h2,
    SPACE_REALM     = 2'h3
  } space_type;

  // Access sequencer
  typedef enum logic {
    ST_IDLE  = 1'b0,
    ST_FETCH = 1'b1
  } state_type;

endpackage

// file: rtl/fraction_mask.sv
// Purpose: Keep only the implemented top bits of a fixed-point fraction field
// Assumes: Implemented bits sit at the most significant end of the field
// Notes:   Pure combinational; low bits always come out zero

`timescale 1ns/1ps

module fraction_mask #(
  parameter int unsigned FIELD = 16,
  parameter int unsigned IMPL  = 8
) (
  input  wire logic [FIELD-1:0] raw_fraction,
  output logic      [FIELD-1:0] kept_fraction
);

  // ==========================================================================
  // Mask
  // ==========================================================================
  localparam logic [FIELD-1:0] KEEP = ~((FIELD'(1) << (FIELD - IMPL)) - FIELD'(1));

  // Unimplemented low bits read as zero and drop writes
  assign kept_fraction = raw_fraction & KEEP;

endmodule

// file: rtl/capacity_table.sv
// Purpose: Small settings table, one write port and one registered read port
// Assumes: Write and read in the same cycle return the old word
// Notes:   Cleared on reset so every setting starts at a known fraction

`timescale 1ns/1ps

module capacity_table #(
  parameter int unsigned WIDTH = 16,
  parameter int unsigned DEPTH = 64,
  parameter int unsigned IBITS = 6
) (
  input  wire logic             sys_clk,
  input  wire logic             rstn,
  input  wire logic             wr_en,
  input  wire logic [IBITS-1:0] wr_index,
  input  wire logic [WIDTH-1:0] wr_data,
  input  wire logic [IBITS-1:0] rd_index,
  output logic      [WIDTH-1:0] rd_data_q
);

  // ==========================================================================
  // Storage
  // ==========================================================================
  logic [WIDTH-1:0] words_q [DEPTH];

  // Write and registered read; flop-based, depth is small
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < DEPTH; i++) begin
        words_q[i] <= '0;
      end
      rd_data_q <= '0;
    end else begin
      if (wr_en) begin
        words_q[wr_index] <= wr_data;
      end
      rd_data_q <= words_q[rd_index];
    end
  end

endmodule

// file: verification/capacity_cfg_checker.sv
// Purpose: Port-level timing and field checks of the cache capacity bank
// Assumes: Default feature set, 8 implemented fraction bits, narrowing absent
// Notes:   Bound onto every instance of the bank

`timescale 1ns/1ps

module capacity_cfg_checker (
  input wire logic        sys_clk,
  input wire logic        rstn,
  input wire logic        acc_req,
  input wire logic [15:0] acc_addr,
  input wire logic [15:0] sel_partition,
  input wire logic [3:0]  sel_instance,
  input wire logic        sel_internal,
  input wire logic        lkp_req,
  input wire logic        acc_busy,
  input wire logic        acc_ack,
  input wire logic        acc_error,
  input wire logic [31:0] acc_rdata,
  input wire logic        lkp_valid,
  input wire logic [15:0] lkp_max_fraction,
  input wire logic [15:0] lkp_min_fraction
);
  // ==========================================================================
  // Sequences and properties
  // ==========================================================================
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  // One busy cycle, then the answer
  sequence s_answer;
    acc_busy ##1 (acc_ack && !acc_busy);
  endsequence
  sequence s_bad_answer;
    acc_busy ##1 (acc_ack && acc_error && acc_rdata == 32'h0);
  endsequence

  property p_ack_timing;
    acc_req && !acc_busy |=> s_answer;
  endproperty
  property p_bad_select;
    acc_req && !acc_busy && (acc_addr == 16'h0108 || acc_addr == 16'h0110) &&
      (sel_partition >= 16'h0008 || sel_instance >= 4'h2 || sel_internal) |=> s_bad_answer;
  endproperty
  // Unmapped offsets read zero without an error
  property p_unmapped;
    acc_req && !acc_busy && acc_addr != 16'h0108 && acc_addr != 16'h0110
      |-> ##2 (acc_ack && !acc_error && acc_rdata == 32'h0);
  endproperty
  property p_min_upper;
    acc_req && !acc_busy && acc_addr == 16'h0110 |-> ##2 acc_rdata[31:16] == 16'h0;
  endproperty
  property p_reserved;
    acc_ack |-> acc_rdata[30:16] == 15'h0;
  endproperty
  property p_low_bits;
    acc_ack |-> acc_rdata[7:0] == 8'h00;
  endproperty
  property p_lookup;
    lkp_req && !acc_req && !acc_busy |=> acc_busy ##1 (lkp_valid && !acc_ack);
  endproperty
  property p_lookup_low;
    lkp_valid |-> lkp_max_fraction[7:0] == 8'h00 && lkp_min_fraction[7:0] == 8'h00;
  endproperty
  // Read data stands between answers
  property p_hold;
    !acc_ack |-> $stable(acc_rdata);
  endproperty

  a_ack_timing: assert property (p_ack_timing) else $error("access answer late or missing");
  a_bad_select: assert property (p_bad_select) else $error("bad selection not refused");
  a_unmapped: assert property (p_unmapped) else $error("unmapped offset answer wrong");
  a_min_upper: assert property (p_min_upper) else $error("min register upper half not zero");
  a_reserved: assert property (p_reserved) else $error("reserved bits not zero");
  a_low_bits: assert property (p_low_bits) else $error("unimplemented fraction bits not zero");
  a_lookup: assert property (p_lookup) else $error("lookup answer late or missing");
  a_lookup_low: assert property (p_lookup_low) else $error("lookup fraction low bits set");
  a_hold: assert property (p_hold) else $error("read data changed between answers");
endmodule

bind cache_capacity_partition_config capacity_cfg_checker chk (.sys_clk(sys_clk), .rstn(rstn),
  .acc_req(acc_req), .acc_addr(acc_addr), .sel_partition(sel_partition), .sel_instance(sel_instance),
  .sel_internal(sel_internal), .lkp_req(lkp_req), .acc_busy(acc_busy), .acc_ack(acc_ack),
  .acc_error(acc_error), .acc_rdata(acc_rdata), .lkp_valid(lkp_valid),
  .lkp_max_fraction(lkp_max_fraction), .lkp_min_fraction(lkp_min_fraction));

// file: verification/tb_cache_capacity_partition_config.sv
// Purpose: Self-checking bench of the cache capacity configuration bank
// Assumes: Default feature parameters, partition 3 instance 1 as the working slot
// Notes:   Expected words are rebuilt from the written values, never read back blindly

`timescale 1ns/1ps

module tb_cache_capacity_partition_config;
  // ==========================================================================
  // Stimulus and observation
  // ==========================================================================
  logic        sys_clk = 1'b0;
  logic        rstn = 1'b0;
  logic        acc_req = 1'b0;
  logic [1:0]  acc_space = 2'h0;
  logic [15:0] acc_addr = 16'h0000;
  logic        acc_write = 1'b0;
  logic [31:0] acc_wdata = 32'h0000_0000;
  logic [15:0] sel_partition = 16'h0000;
  logic [3:0]  sel_instance = 4'h0;
  logic        sel_internal = 1'b0;
  logic        lkp_req = 1'b0;
  logic [1:0]  lkp_space = 2'h0;
  logic        lkp_instance = 1'b0;
  logic [2:0]  lkp_partition = 3'h0;
  logic        acc_busy, acc_ack, acc_error, lkp_valid, lkp_relax;
  logic [31:0] acc_rdata, rd;
  logic [15:0] lkp_max_fraction, lkp_min_fraction;
  logic        er;
  int          fails = 0;
  int          cmp_count = 0;
  // One pattern per space; space 0 holds the largest fraction
  localparam logic [31:0] WVALS [4] = '{32'hffff_ffff, 32'h0000_12ab, 32'h8000_a5c3, 32'h7fff_0f77};
  localparam logic [15:0] MAX_A = capacity_cfg_pkg::MAX_OFFSET;
  localparam logic [15:0] MIN_A = capacity_cfg_pkg::MIN_OFFSET;

  always #20 sys_clk = ~sys_clk;

  cache_capacity_partition_config dut (.sys_clk(sys_clk), .rstn(rstn), .acc_req(acc_req),
    .acc_space(acc_space), .acc_addr(acc_addr), .acc_write(acc_write), .acc_wdata(acc_wdata),
    .sel_partition(sel_partition), .sel_instance(sel_instance), .sel_internal(sel_internal),
    .lkp_req(lkp_req), .lkp_space(lkp_space), .lkp_instance(lkp_instance), .lkp_partition(lkp_partition),
    .acc_busy(acc_busy), .acc_ack(acc_ack), .acc_error(acc_error), .acc_rdata(acc_rdata),
    .lkp_valid(lkp_valid), .lkp_max_fraction(lkp_max_fraction), .lkp_relax(lkp_relax),
    .lkp_min_fraction(lkp_min_fraction));

  // ==========================================================================
  // Compare and bus tasks
  // ==========================================================================
  task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_bit(input string what, input logic exp, input logic got);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("mismatch %s expected %b seen %b", what, exp, got);
    end
  endtask

  // Request held one cycle only: taken at once since the sequencer is idle
  task automatic access(input logic [1:0] sp, input logic [15:0] ad, input logic wr, input logic [31:0] wd,
                        input logic [15:0] pt, input logic [3:0] ins, input logic it);
    int n;
    @(posedge sys_clk);
    acc_req <= 1'b1;
    acc_space <= sp;
    acc_addr <= ad;
    acc_write <= wr;
    acc_wdata <= wd;
    sel_partition <= pt;
    sel_instance <= ins;
    sel_internal <= it;
    @(posedge sys_clk);
    acc_req <= 1'b0;
    acc_wdata <= ~wd;
    #1;
    for (n = 0; n < 4 && acc_ack !== 1'b1; n++) begin
      @(posedge sys_clk);
      #1;
    end
    chk_bit("access answer", 1'b1, acc_ack);
    rd = acc_rdata;
    er = acc_error;
  endtask

  task automatic lookup(input logic [1:0] sp, input logic ins, input logic [2:0] pt);
    int n;
    @(posedge sys_clk);
    lkp_req <= 1'b1;
    lkp_space <= sp;
    lkp_instance <= ins;
    lkp_partition <= pt;
    @(posedge sys_clk);
    lkp_req <= 1'b0;
    #1;
    for (n = 0; n < 4 && lkp_valid !== 1'b1; n++) begin
      @(posedge sys_clk);
      #1;
    end
    chk_bit("lookup answer", 1'b1, lkp_valid);
  endtask

  // ==========================================================================
  // Scenarios
  // ==========================================================================
  task automatic t_reset_clear();
    for (int s = 0; s < 4; s++) begin
      access(s[1:0], MAX_A, 1'b0, 32'h0, 16'h0003, 4'h1, 1'b0);
      chk_word("max after reset", 32'h0, rd);
      access(s[1:0], MIN_A, 1'b0, 32'h0, 16'h0003, 4'h1, 1'b0);
      chk_word("min after reset", 32'h0, rd);
      chk_bit("min error", 1'b0, er);
    end
  endtask

  // Distinct words per space; a shared store would show the last one everywhere
  task automatic t_spaces();
    logic [31:0] w;
    for (int s = 0; s < 4; s++) begin
      access(s[1:0], MAX_A, 1'b1, WVALS[s], 16'h0003, 4'h1, 1'b0);
      chk_word("max write old value", 32'h0, rd);
      access(s[1:0], MIN_A, 1'b1, WVALS[s] ^ 32'h0000_f000, 16'h0003, 4'h1, 1'b0);
    end
    for (int s = 0; s < 4; s++) begin
      w = WVALS[s];
      access(s[1:0], MAX_A, 1'b0, 32'h0, 16'h0003, 4'h1, 1'b0);
      chk_word("max readback", {w[31], 15'h0, w[15:8], 8'h00}, rd);
      w = WVALS[s] ^ 32'h0000_f000;
      access(s[1:0], MIN_A, 1'b0, 32'h0, 16'h0003, 4'h1, 1'b0);
      chk_word("min readback", {16'h0, w[15:8], 8'h00}, rd);
    end
  endtask

  task automatic t_instance();
    access(2'h0, MAX_A, 1'b0, 32'h0, 16'h0003, 4'h0, 1'b0);
    chk_word("other instance", 32'h0, rd);
    access(2'h0, MIN_A, 1'b0, 32'h0, 16'h0002, 4'h1, 1'b0);
    chk_word("other partition", 32'h0, rd);
  endtask

  // Out-of-range partition, instance, and a set internal bit
  task automatic t_refused();
    for (int i = 0; i < 3; i++) begin
      access(2'h1, MAX_A, 1'b1, 32'hffff_ffff, (i == 0) ? 16'h0008 : 16'h0003, (i == 1) ? 4'h2 : 4'h1, i == 2);
      chk_bit("refused error", 1'b1, er);
      chk_word("refused data", 32'h0, rd);
    end
    access(2'h1, MAX_A, 1'b0, 32'h0, 16'h0003, 4'h1, 1'b0);
    chk_word("max kept", {16'h0, WVALS[1][15:8], 8'h00}, rd);
    access(2'h1, MAX_A, 1'b0, 32'h0, 16'h0000, 4'h1, 1'b0);
    chk_word("partition alias", 32'h0, rd);
    access(2'h1, MAX_A, 1'b0, 32'h0, 16'h0003, 4'h0, 1'b0);
    chk_word("instance alias", 32'h0, rd);
    access(2'h1, 16'h0118, 1'b0, 32'h0, 16'h0003, 4'h1, 1'b0);
    chk_word("unmapped read", 32'h0, rd);
    chk_bit("unmapped error", 1'b0, er);
  endtask

  task automatic t_lookup();
    logic [31:0] m;
    for (int s = 0; s < 4; s++) begin
      m = WVALS[s] ^ 32'h0000_f000;
      lookup(s[1:0], 1'b1, 3'h3);
      chk_word("lookup max", {16'h0, WVALS[s][15:8], 8'h00}, {16'h0, lkp_max_fraction});
      chk_bit("lookup relax", WVALS[s][31], lkp_relax);
      chk_word("lookup min", {16'h0, m[15:8], 8'h00}, {16'h0, lkp_min_fraction});
    end
  endtask

  // ==========================================================================
  // Sequence, watchdog and verdict
  // ==========================================================================
  task automatic close_out();
    if (fails == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    repeat (16) @(posedge sys_clk);
    rstn <= 1'b1;
    t_reset_clear();
    t_spaces();
    t_instance();
    t_refused();
    t_lookup();
    close_out();
  end

  // About 130 cycles of traffic; a generous margin before giving up
  initial begin
    repeat (3000) @(posedge sys_clk);
    fails++;
    close_out();
  end
endmodule
